// File: hw/hcp_commutator.sv
// Functional notes
// R1: three sensors form code, six valid
// R2: select input switches 60 or 120 decoding
// R3: valid code picks one high, one low
// R4: direction flip swaps same-letter drives
// R5: direction reverses commutation order
// R6: floating run enable counts as asserted
// R7: run enable low: drives off, coast
// R8: ramp restart sets both gating latches
// R9: speed compare resets upper latch
// R10: pwm chops only the low side
// R11: select high 60 degrees, low 120
// R12: invalid code turns every drive off
// R13: high side drives are active low
// R14: current limit resets lower latch
// R15: inputs synchronised; latch reset beats set
`include "hcp_defines.svh"
`default_nettype none
module hcp_commutator
  import hcp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic rotorSensorA,
  input wire logic rotorSensorB,
  input wire logic rotorSensorC,
  input wire logic dirForward,
  input wire logic runEnable,
  input wire logic phaseSel60,
  input wire logic rampRestart,
  input wire logic pwmTrip,
  input wire logic currentTrip,
  input wire logic [`HCP_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic highSideDrivePhaseA_n,
  output logic highSideDrivePhaseB_n,
  output logic highSideDrivePhaseC_n,
  output logic lowSideDrivePhaseA,
  output logic lowSideDrivePhaseB,
  output logic lowSideDrivePhaseC
);

  // decode one sensor code for forward rotation
  function automatic hcp_step_s decodeFwd(input hcp_code_t code,
                                          input hcp_phasing_e ph);
    hcp_step_s s;
    s = '0;
    s.valid = 1'b1;
    if (ph == HCP_PH60) begin // see R11
      case (code) // see R2
        3'h4: begin s.high = 3'h1; s.low = 3'h4; end
        3'h6: begin s.high = 3'h2; s.low = 3'h4; end
        3'h7: begin s.high = 3'h2; s.low = 3'h1; end
        3'h3: begin s.high = 3'h4; s.low = 3'h1; end
        3'h1: begin s.high = 3'h4; s.low = 3'h2; end
        3'h0: begin s.high = 3'h1; s.low = 3'h2; end
        default: s = '0; // see R12
      endcase
    end else begin
      case (code) // see R2
        3'h4: begin s.high = 3'h1; s.low = 3'h4; end
        3'h6: begin s.high = 3'h2; s.low = 3'h4; end
        3'h2: begin s.high = 3'h2; s.low = 3'h1; end
        3'h3: begin s.high = 3'h4; s.low = 3'h1; end
        3'h1: begin s.high = 3'h4; s.low = 3'h2; end
        3'h5: begin s.high = 3'h1; s.low = 3'h2; end
        default: s = '0; // see R12
      endcase
    end
    return s;
  endfunction

  // reverse rotation swaps the roles of high and low selects
  function automatic hcp_step_s swapRoles(input hcp_step_s s);
    hcp_step_s r;
    r = s;
    r.high = s.low;
    r.low = s.high;
    return r;
  endfunction

  // synchronised copies of every pin input
  logic [`HCP_SYNC_W-1:0] pinRaw;
  logic [`HCP_SYNC_W-1:0] pinSync;
  logic [`HCP_SYNC_W-1:0] pinIdle;
  hcp_code_t codeS;
  logic fwdS;
  logic enS;
  logic sel60S;
  logic restartS;
  logic pwmS;
  logic ilimS;

  assign pinRaw = {rotorSensorA, rotorSensorB, rotorSensorC, dirForward,
                   runEnable, phaseSel60, rampRestart, pwmTrip,
                   currentTrip};
  // the pad pull-up makes a floating enable read high
  assign pinIdle = `HCP_PIN_IDLE; // see R6

  hcp_sync #(
    .Width(`HCP_SYNC_W)
  ) u_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clkEn(clkEn),
    .asyncIn(pinRaw),
    .resetVal(pinIdle),
    .syncOut(pinSync)
  ); // see R15

  assign codeS = pinSync[8:6]; // see R1
  assign fwdS = pinSync[5];
  assign enS = pinSync[4];
  assign sel60S = pinSync[3];
  assign restartS = pinSync[2];
  assign pwmS = pinSync[1];
  assign ilimS = pinSync[0];

  // register state
  logic [31:0] ctrl_q;
  logic [31:0] ctrl_d;
  logic [`HCP_CNT_W-1:0] cycles_q;
  logic [`HCP_CNT_W-1:0] cycles_d;
  logic [`HCP_CNT_W-1:0] limits_q;
  logic [`HCP_CNT_W-1:0] limits_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;

  // gating and drive state
  logic restartPrev_q;
  logic upper_q;
  logic upper_d;
  logic lower_q;
  logic lower_d;
  logic [2:0] high_n_q;
  logic [2:0] high_n_d;
  logic [2:0] low_q;
  logic [2:0] low_d;

  hcp_step_s stepFwd;
  hcp_step_s stepRev;
  hcp_step_s step;
  logic restartEdge;
  logic runOn;
  logic bothLatched;
  logic upperEnd;
  logic lowerEnd;

  // decoder for both directions, the pin picks one
  always_comb begin
    stepFwd = decodeFwd(codeS, sel60S ? HCP_PH60 : HCP_PH120);
    stepRev = swapRoles(stepFwd); // see R4
    step = fwdS ? stepFwd : stepRev; // see R5
  end

  assign restartEdge = restartS && !restartPrev_q;
  assign runOn = enS && ctrl_q[`HCP_CTRL_RUN_BIT]; // see R6
  assign bothLatched = upper_q && lower_q;
  assign upperEnd = upper_q && pwmS;
  assign lowerEnd = lower_q && ilimS;

  // dual latch pwm gating, reset takes priority over set
  always_comb begin
    upper_d = upper_q;
    lower_d = lower_q;
    if (restartEdge) begin
      upper_d = 1'b1; // see R8
      lower_d = 1'b1; // see R8
    end
    if (pwmS) begin
      upper_d = 1'b0; // see R9 see R15
    end
    if (ilimS) begin
      lower_d = 1'b0; // see R14 see R15
    end
  end

  // drive outputs, high side steady, low side chopped
  always_comb begin
    high_n_d = 3'h7;
    low_d = 3'h0;
    if (step.valid && runOn) begin // see R7 see R12
      high_n_d = ~step.high; // see R10 see R13
      low_d = bothLatched ? step.low : 3'h0; // see R10 see R3
    end
  end

  // apb slave: one wait state, then a single ready pulse
  always_comb begin
    ctrl_d = ctrl_q;
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    pready_d = 1'b0;
    cycles_d = restartEdge ? cycles_q + 1'b1 : cycles_q;
    limits_d = lowerEnd ? limits_q + 1'b1 : limits_q;
    if (psel && penable && !pready_q) begin
      pready_d = 1'b1;
      prdata_d = 32'h00000000;
      if (paddr == `HCP_CTRL_ADDR) begin
        prdata_d = ctrl_q;
      end else if (paddr == `HCP_STATUS_ADDR) begin
        prdata_d[`HCP_STAT_POS_LSB +: 3] = codeS;
        prdata_d[`HCP_STAT_VALID_BIT] = stepFwd.valid;
        prdata_d[`HCP_STAT_UPPER_BIT] = upper_q;
        prdata_d[`HCP_STAT_LOWER_BIT] = lower_q;
        prdata_d[`HCP_STAT_SEL60_BIT] = sel60S;
        prdata_d[`HCP_STAT_FWD_BIT] = fwdS;
        prdata_d[`HCP_STAT_EN_BIT] = enS;
      end else if (paddr == `HCP_CYCLES_ADDR) begin
        prdata_d[`HCP_CNT_W-1:0] = cycles_q;
      end else if (paddr == `HCP_LIMITS_ADDR) begin
        prdata_d[`HCP_CNT_W-1:0] = limits_q;
      end else begin
        pslverr_d = 1'b1;
      end
      if (!pwrite) begin
        prdata_d = pslverr_d ? 32'h00000000 : prdata_d;
      end
    end
    if (psel && penable && pready_q && pwrite) begin
      if (paddr == `HCP_CTRL_ADDR && pstrb[0]) begin
        ctrl_d = {31'h00000000, pwdata[`HCP_CTRL_RUN_BIT]};
      end else if (paddr == `HCP_CYCLES_ADDR && pstrb[0]) begin
        cycles_d = '0;
      end else if (paddr == `HCP_LIMITS_ADDR && pstrb[0]) begin
        limits_d = '0;
      end
    end
  end

  // every state element, frozen while the clock enable is low
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= `HCP_CTRL_RESET;
      cycles_q <= '0;
      limits_q <= '0;
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      restartPrev_q <= 1'b0;
      upper_q <= 1'b0;
      lower_q <= 1'b0;
      high_n_q <= 3'h7;
      low_q <= 3'h0;
    end else if (clkEn) begin
      ctrl_q <= ctrl_d;
      cycles_q <= cycles_d;
      limits_q <= limits_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      restartPrev_q <= restartS;
      upper_q <= upper_d;
      lower_q <= lower_d;
      high_n_q <= high_n_d;
      low_q <= low_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign highSideDrivePhaseA_n = high_n_q[0];
  assign highSideDrivePhaseB_n = high_n_q[1];
  assign highSideDrivePhaseC_n = high_n_q[2];
  assign lowSideDrivePhaseA = low_q[0];
  assign lowSideDrivePhaseB = low_q[1];
  assign lowSideDrivePhaseC = low_q[2];

  // checks on the drive, latch and apb ready behaviour
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  chk_invalid_all_off: assert property ( // see R12
    clkEn && !stepFwd.valid |=> high_n_q == 3'h7 && low_q == 3'h0)
    else $error("drive active on invalid sensor code");

  chk_one_high_side: assert property ( // see R3
    $onehot0(~high_n_q) && $onehot0(low_q))
    else $error("more than one drive selected per side");

  chk_low_needs_latch: assert property ( // see R9
    $past(clkEn) && |low_q |-> $past(bothLatched))
    else $error("low drive on without both latches set");

  chk_run_off_coast: assert property ( // see R7
    clkEn && !enS |=> high_n_q == 3'h7 && low_q == 3'h0)
    else $error("drive active while run enable low");

  chk_reset_beats_set: assert property ( // see R15
    clkEn && pwmS && restartEdge |=> !upper_q)
    else $error("upper latch set despite speed compare");

  chk_restart_sets: assert property ( // see R8
    clkEn && restartEdge && !pwmS && !ilimS |=> upper_q && lower_q)
    else $error("ramp restart did not set the latches");

  chk_high_steady: assert property ( // see R10
    clkEn && step.valid && runOn |=> high_n_q == ~$past(step.high))
    else $error("high side drive not held for the step");

  chk_dir_swap_roles: assert property ( // see R4
    clkEn && stepFwd.valid && runOn && !fwdS
      |=> high_n_q == ~$past(stepFwd.low))
    else $error("reverse step does not swap phase roles");

  chk_single_pulse: assert property ( // see R14
    clkEn && !lower_q && !restartEdge |=> !lower_q)
    else $error("second conduction pulse in one cycle");

  chk_limit_ends_pulse: assert property ( // see R14
    clkEn && ilimS |=> !lower_q ##1 (!$past(clkEn) || low_q == 3'h0))
    else $error("current limit did not end conduction");

  chk_ready_pulse: assert property (
    pready_q && clkEn |=> !pready_q)
    else $error("apb ready held longer than one cycle");

endmodule
`default_nettype wire

// File: hw/hcp_defines.svh
`ifndef HCP_DEFINES_SVH
`define HCP_DEFINES_SVH

// register map, byte addresses on the apb bus
`define HCP_ADDR_W 12
`define HCP_CTRL_ADDR 12'h000
`define HCP_STATUS_ADDR 12'h004
`define HCP_CYCLES_ADDR 12'h008
`define HCP_LIMITS_ADDR 12'h00c

// control register fields and reset value
`define HCP_CTRL_RUN_BIT 0
`define HCP_CTRL_RESET 32'h00000001

// status register fields
`define HCP_STAT_POS_LSB 0
`define HCP_STAT_VALID_BIT 3
`define HCP_STAT_UPPER_BIT 4
`define HCP_STAT_LOWER_BIT 5
`define HCP_STAT_SEL60_BIT 6
`define HCP_STAT_FWD_BIT 7
`define HCP_STAT_EN_BIT 8

// event counter width and synchronised input count
`define HCP_CNT_W 16
`define HCP_SYNC_W 9
// synchroniser idle value: enable and forward high, sensors 000 at 120
// degrees, which decodes as invalid so no drive glitches out of reset
`define HCP_PIN_IDLE 9'h030

`endif

// File: hw/hcp_pkg.sv
`default_nettype none
package hcp_pkg;
  // three sensor bits, sensor a in bit 2
  typedef logic [2:0] hcp_code_t;
  // one-hot phase select, phase a in bit 0
  typedef logic [2:0] hcp_phase_t;
  // decoder answer for one direction
  typedef struct packed {
    logic valid;
    hcp_phase_t high;
    hcp_phase_t low;
  } hcp_step_s;
  // sensor phasing convention
  typedef enum logic {HCP_PH120, HCP_PH60} hcp_phasing_e;
endpackage
`default_nettype wire

// File: hw/hcp_sync.sv
`default_nettype none
module hcp_sync #(
  parameter int Width = 9
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic [Width-1:0] asyncIn,
  input wire logic [Width-1:0] resetVal,
  output logic [Width-1:0] syncOut
);
  logic [Width-1:0] stage1_q;
  logic [Width-1:0] stage2_q;
  logic [Width-1:0] stage1_d;
  logic [Width-1:0] stage2_d;
  logic primed_q;

  // two flop chain, the first stage feeds only the second
  always_comb begin
    stage1_d = asyncIn;
    stage2_d = primed_q ? stage1_q : resetVal;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      stage1_q <= '0;
      stage2_q <= '0;
      primed_q <= 1'b0;
    end else if (clkEn) begin
      stage1_q <= stage1_d;
      stage2_q <= stage2_d;
      primed_q <= 1'b1;
    end
  end

  assign syncOut = stage2_q;
endmodule
`default_nettype wire

// File: sim/hall_commutation_pwm_gating_tb_top.sv
`include "hcp_defines.svh"
`default_nettype none
module hall_commutation_pwm_gating_tb_top;
  import hcp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, resetn, clkEn, dirFwd, runEn, sel60, e;
  logic rampRestart, pwmTrip, currentTrip, psel, penable, pwrite;
  logic sA, sB, sC, pready, pslverr;
  logic [`HCP_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] step, hiN, lo;
  logic [2:0] hiT [6] = '{3'h1, 3'h2, 3'h2, 3'h4, 3'h4, 3'h1};
  logic [2:0] loT [6] = '{3'h4, 3'h4, 3'h1, 3'h1, 3'h2, 3'h2};
  int n_fail, checks;
  hcp_hall_model u_hall (.step(step), .sel60(sel60), .sensA(sA),
    .sensB(sB), .sensC(sC));
  hcp_commutator u_dut (.clk_sys(clk_sys), .resetn(resetn), .clkEn(clkEn),
    .rotorSensorA(sA), .rotorSensorB(sB), .rotorSensorC(sC),
    .dirForward(dirFwd), .runEnable(runEn), .phaseSel60(sel60),
    .rampRestart(rampRestart), .pwmTrip(pwmTrip),
    .currentTrip(currentTrip), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .highSideDrivePhaseA_n(hiN[0]), .highSideDrivePhaseB_n(hiN[1]),
    .highSideDrivePhaseC_n(hiN[2]), .lowSideDrivePhaseA(lo[0]),
    .lowSideDrivePhaseB(lo[1]), .lowSideDrivePhaseC(lo[2]));
  // 25 mhz system clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic complete_run;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
    input string nm);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // drive state as one-hot high and low phases, high side shown inverted
  task automatic drv(input logic [2:0] h, input logic [2:0] l);
    chk({26'h0, hiN, lo}, {26'h0, ~h, l}, "drives");
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // only the watchdog ends a hung wait
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // oscillator cycle start, long enough to pass the synchronisers
  task automatic restart;
    @(posedge clk_sys);
    rampRestart <= 1'b1;
    cyc(3);
    rampRestart <= 1'b0;
    cyc(6);
  endtask
  // watchdog against a hung handshake
  initial begin
    #(5000 * 40);
    n_fail++;
    complete_run;
  end
  // main sequence
  initial begin
    {resetn, rampRestart, pwmTrip, currentTrip, psel, penable} = 6'h0;
    {clkEn, dirFwd, runEn, sel60, pwrite} = 5'h1e;
    paddr = 12'h0;
    pwdata = 32'h0;
    step = 3'h0;
    cyc(8);
    resetn <= 1'b1;
    drv(3'h0, 3'h0);
    apb(1'b0, `HCP_CTRL_ADDR, 32'h0);
    chk(rd, 32'h1, "ctrl");
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, e}, 32'h1, "unmapped");
    for (int s = 0; s < 2; s++) begin
      for (int f = 0; f < 2; f++) begin
        for (int k = 0; k < 8; k++) begin
          @(posedge clk_sys);
          sel60 <= s[0];
          dirFwd <= f[0];
          step <= k[2:0];
          restart;
          if (k > 5) drv(3'h0, 3'h0);
          else if (f) drv(hiT[k], loT[k]);
          else drv(loT[k], hiT[k]);
        end
      end
    end
    @(posedge clk_sys);
    step <= 3'h0;
    restart;
    pwmTrip <= 1'b1;
    cyc(6);
    drv(3'h1, 3'h0);
    restart;
    drv(3'h1, 3'h0);
    pwmTrip <= 1'b0;
    cyc(6);
    drv(3'h1, 3'h0);
    restart;
    drv(3'h1, 3'h4);
    currentTrip <= 1'b1;
    restart;
    drv(3'h1, 3'h0);
    currentTrip <= 1'b0;
    runEn <= 1'b0;
    restart;
    drv(3'h0, 3'h0);
    runEn <= 1'b1;
    restart;
    drv(3'h1, 3'h4);
    apb(1'b1, `HCP_CTRL_ADDR, 32'h0);
    cyc(6);
    drv(3'h0, 3'h0);
    apb(1'b1, `HCP_CTRL_ADDR, 32'h1);
    restart;
    clkEn <= 1'b0;
    step <= 3'h1;
    cyc(6);
    drv(3'h1, 3'h4);
    clkEn <= 1'b1;
    cyc(6);
    drv(3'h2, 3'h4);
    // status: code 110, valid, both latches, 60 deg, forward, enabled
    apb(1'b0, `HCP_STATUS_ADDR, 32'h0);
    chk(rd, 32'h000001fe, "status");
    apb(1'b0, `HCP_LIMITS_ADDR, 32'h0);
    chk(rd, 32'h00000001, "limits");
    apb(1'b1, `HCP_CYCLES_ADDR, 32'h0);
    restart;
    restart;
    apb(1'b0, `HCP_CYCLES_ADDR, 32'h0);
    chk(rd, 32'h00000002, "cycles");
    complete_run;
  end
endmodule
`default_nettype wire

// File: sim/hcp_hall_model.sv
`default_nettype none
module hcp_hall_model (
  input wire logic [2:0] step,
  input wire logic sel60,
  output logic sensA,
  output logic sensB,
  output logic sensC
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] code;
  // rotor step to sensor code, steps 6 and 7 act as a broken sensor line
  always_comb begin
    case (step)
      3'h0: code = 3'h4;
      3'h1: code = 3'h6;
      3'h2: code = sel60 ? 3'h7 : 3'h2;
      3'h3: code = 3'h3;
      3'h4: code = 3'h1;
      3'h5: code = sel60 ? 3'h0 : 3'h5;
      3'h6: code = sel60 ? 3'h5 : 3'h7;
      default: code = sel60 ? 3'h2 : 3'h0;
    endcase
  end
  // sensor a is the most significant bit
  assign {sensA, sensB, sensC} = code;
endmodule
`default_nettype wire
